// ---- nand_host_pkg.sv ----
package nand_host_pkg;
    localparam int          STROBE_LOW_NS   = 25;
    localparam int          STROBE_HIGH_NS  = 15;
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          ADDR_CYCLES     = 4;
    localparam int          PAGE_BITS       = 6;
    localparam int          BLOCK_BITS      = 10;
    localparam int          COL_BITS_X8     = 12;
    localparam int          COL_BITS_X16    = 11;
    localparam logic [7:0]  CMD_RESET       = 8'hff;
    localparam logic [1:0]  OP_CMD          = 2'h0;
    localparam logic [1:0]  OP_ADDR         = 2'h1;
    localparam logic [1:0]  OP_WRITE        = 2'h2;
    localparam logic [1:0]  OP_READ         = 2'h3;
endpackage

// ---- host_fifo.sv ----
`timescale 1ns/1ps
module host_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,     // System clock
    input  wire logic             rst,       // Synchronous reset
    input  wire logic             in_valid,  // Write request
    output logic                  in_ready,  // Room available
    input  wire logic [WIDTH-1:0] in_data,   // Write data
    output logic                  out_valid, // Data available
    input  wire logic             out_ready, // Read accept
    output logic      [WIDTH-1:0] out_data   // Read data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wptr_r;
    logic [AW:0]      rptr_r;

    // Pointer based full and empty
    assign in_ready  = (wptr_r - rptr_r) != (AW+1)'(DEPTH);
    assign out_valid = wptr_r != rptr_r;
    assign out_data  = mem_r[rptr_r[AW-1:0]];

    // Storage write
    always_ff @(posedge clock) begin
        if (in_valid && in_ready) begin
            mem_r[wptr_r[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clock) begin
        if (rst) begin
            wptr_r <= '0;
            rptr_r <= '0;
        end else begin
            if (in_valid && in_ready) wptr_r <= wptr_r + 1'b1;
            if (out_valid && out_ready) rptr_r <= rptr_r + 1'b1;
        end
    end

    chk_no_overflow: assert property (@(posedge clock) disable iff (rst)
        (wptr_r - rptr_r) <= (AW+1)'(DEPTH)) else $error("fifo overflow");
endmodule

// ---- nand_host.sv ----
`timescale 1ns/1ps
module nand_host
    import nand_host_pkg::*;
#(
    parameter int BUS16 = 0
) (
    input  wire logic        clock,            // System clock
    input  wire logic        rst,              // Synchronous reset
    input  wire logic        op_valid,         // Operation request
    output logic             op_ready,         // Operation accepted
    input  wire logic [1:0]  op_kind,          // Cycle kind
    input  wire logic [7:0]  op_cmd,           // Command byte
    input  wire logic [11:0] op_column,        // Column address
    input  wire logic [5:0]  op_page,          // Page within block
    input  wire logic [9:0]  op_block,         // Block address
    input  wire logic [15:0] op_wdata,         // Write data word
    output logic             rd_valid,         // Read data available
    input  wire logic        rd_ready,         // Read data taken
    output logic      [15:0] rd_data,          // Read data word
    input  wire logic        guard_release,    // Allow modification
    output logic             reset_done,       // Reset command issued
    output logic             die_ready,        // Synced ready level
    output logic             target_select_n,  // Chip enable pin
    output logic             cmd_latch_en,     // Command latch pin
    output logic             addr_latch_en,    // Address latch pin
    output logic             write_strobe_n,   // Write strobe pin
    output logic             read_strobe_n,    // Read strobe pin
    output logic             prog_guard_n,     // Write protect pin
    output logic      [15:0] io_out,           // Bus drive value
    output logic      [15:0] io_oe,            // Bus drive enable
    input  wire logic [15:0] io_in,            // Bus sampled value
    input  wire logic        ready_busy_n      // Ready/busy pin
);
    initial begin
        if (BUS16 != 0 && BUS16 != 1) $error("BUS16 must be 0 or 1");
    end

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOW   = 3'b001,
        ST_HIGH  = 3'b010,
        ST_NEXT  = 3'b011,
        ST_WAIT  = 3'b100
    } state_t;

    ////////////////////////////////////////////////////////////////////////
    // Pin input synchronisers
    logic        rb_s1_r;
    logic        rb_s2_r;
    logic [15:0] io_s1_r;
    logic [15:0] io_s2_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            rb_s1_r <= 1'b0;
            rb_s2_r <= 1'b0;
            io_s1_r <= 16'h0000;
            io_s2_r <= 16'h0000;
        end else begin
            rb_s1_r <= ready_busy_n;
            rb_s2_r <= rb_s1_r;
            io_s1_r <= io_in;
            io_s2_r <= io_s1_r;
        end
    end
    assign die_ready = rb_s2_r;

    ////////////////////////////////////////////////////////////////////////
    // Address cycle byte mapping
    function automatic logic [7:0] addr_byte(input logic [1:0] idx, input logic [11:0] col,
                                             input logic [5:0] pg, input logic [9:0] blk);
        logic [15:0] row;
        row = {blk, pg};
        unique case (idx)
            2'd0: addr_byte = col[7:0];
            2'd1: addr_byte = (BUS16 != 0) ? {5'b00000, col[10:8]} : {4'h0, col[11:8]};
            2'd2: addr_byte = row[7:0];
            2'd3: addr_byte = row[15:8];
        endcase
    endfunction

    // Clears bits that must be zero
    function automatic logic [11:0] legal_col(input logic [11:0] col);
        if (BUS16 == 0 && col[11]) legal_col = {col[11], 5'b00000, col[5:0]};
        else if (BUS16 != 0 && col[10]) legal_col = {1'b0, col[10], 5'b00000, col[4:0]};
        else if (BUS16 != 0) legal_col = {1'b0, col[10:0]};
        else legal_col = col;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Write data buffer
    logic        wf_in_ready;
    logic        wf_out_valid;
    logic [15:0] wf_out_data;
    logic        wf_pop;
    logic        wr_push;

    // Buffer fed on accepted writes only

    host_fifo #(.WIDTH(16), .DEPTH(16)) wr_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (wr_push),
        .in_ready  (wf_in_ready),
        .in_data   (op_wdata),
        .out_valid (wf_out_valid),
        .out_ready (wf_pop),
        .out_data  (wf_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    state_t      state_r;
    logic [1:0]  kind_r;
    logic [7:0]  cmd_r;
    logic [11:0] col_r;
    logic [5:0]  page_r;
    logic [9:0]  block_r;
    logic [1:0]  acnt_r;
    logic [1:0]  tcnt_r;
    logic        reset_done_r;
    logic        rd_full_r;
    logic [15:0] rd_data_r;
    logic        accept;

    // Only reset command accepted before the first reset
    assign op_ready = (state_r == ST_IDLE) &&
                      (reset_done_r || (op_kind == OP_CMD && op_cmd == CMD_RESET)) &&
                      (op_kind != OP_READ || !rd_full_r) &&
                      (op_kind != OP_WRITE || wf_in_ready);
    assign accept   = op_valid && op_ready;
    assign wr_push  = accept && op_kind == OP_WRITE;
    assign wf_pop   = state_r == ST_NEXT && kind_r == OP_WRITE;
    assign rd_valid = rd_full_r;
    assign rd_data  = rd_data_r;
    assign reset_done = reset_done_r;

    // Main cycle sequencer
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r <= ST_IDLE;
            kind_r  <= OP_CMD;
            cmd_r   <= 8'h00;
            col_r   <= 12'h000;
            page_r  <= 6'h00;
            block_r <= 10'h000;
            acnt_r  <= 2'd0;
            tcnt_r  <= 2'd0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (accept) begin
                        kind_r  <= op_kind;
                        cmd_r   <= op_cmd;
                        col_r   <= legal_col(op_column);
                        page_r  <= op_page;
                        block_r <= op_block;
                        acnt_r  <= 2'd0;
                        tcnt_r  <= 2'(STROBE_LOW_CYC - 1);
                        // Waits a cycle for write data
                        state_r <= (op_kind == OP_WRITE) ? ST_WAIT : ST_LOW;
                    end
                end
                ST_WAIT: state_r <= ST_LOW;
                ST_LOW: begin
                    if (tcnt_r == 2'd0) begin
                        tcnt_r  <= 2'(STROBE_HIGH_CYC - 1);
                        state_r <= ST_HIGH;
                    end else begin
                        tcnt_r <= tcnt_r - 2'd1;
                    end
                end
                ST_HIGH: begin
                    if (tcnt_r == 2'd0) begin
                        state_r <= ST_NEXT;
                    end else begin
                        tcnt_r <= tcnt_r - 2'd1;
                    end
                end
                ST_NEXT: begin
                    if (kind_r == OP_ADDR && acnt_r != 2'(ADDR_CYCLES - 1)) begin
                        acnt_r  <= acnt_r + 2'd1;
                        tcnt_r  <= 2'(STROBE_LOW_CYC - 1);
                        state_r <= ST_LOW;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            reset_done_r <= 1'b0;
        end else if (state_r == ST_NEXT && kind_r == OP_CMD && cmd_r == CMD_RESET) begin
            reset_done_r <= 1'b1;
        end
    end

    // Read data captured at the strobe rising edge
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_full_r <= 1'b0;
            rd_data_r <= 16'h0000;
        end else if (state_r == ST_NEXT && kind_r == OP_READ) begin
            rd_full_r <= 1'b1;
            rd_data_r <= (BUS16 != 0) ? io_s2_r : {8'h00, io_s2_r[7:0]};
        end else if (rd_ready) begin
            rd_full_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive registers
    logic        active;
    logic        strobe_low;
    logic [15:0] bus_nxt;

    assign active     = state_r == ST_LOW || state_r == ST_HIGH;
    assign strobe_low = state_r == ST_LOW;

    always_comb begin
        bus_nxt = 16'h0000;
        unique case (kind_r)
            // Low byte only for command and address
            OP_CMD:   bus_nxt = {8'h00, cmd_r};
            OP_ADDR:  bus_nxt = {8'h00, addr_byte(acnt_r, col_r, page_r, block_r)};
            OP_WRITE: bus_nxt = (BUS16 != 0) ? wf_out_data : {8'h00, wf_out_data[7:0]};
            OP_READ:  bus_nxt = 16'h0000;
        endcase
    end

    // Select released between operations for bus sharing
    always_ff @(posedge clock) begin
        if (rst) begin
            target_select_n <= 1'b1;
            cmd_latch_en    <= 1'b0;
            addr_latch_en   <= 1'b0;
            write_strobe_n  <= 1'b1;
            read_strobe_n   <= 1'b1;
            io_out          <= 16'h0000;
            io_oe           <= 16'h0000;
        end else begin
            target_select_n <= !active;
            cmd_latch_en    <= active && kind_r == OP_CMD;
            addr_latch_en   <= active && kind_r == OP_ADDR;
            write_strobe_n  <= !(strobe_low && kind_r != OP_READ);
            read_strobe_n   <= !(strobe_low && kind_r == OP_READ);
            io_out          <= bus_nxt;
            io_oe           <= (active && kind_r != OP_READ) ? 16'hffff : 16'h0000;
        end
    end

    // Protection unless released and reset done
    always_ff @(posedge clock) begin
        if (rst) begin
            prog_guard_n <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            prog_guard_n <= guard_release && reset_done_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Command cycle shape
    chk_cmd_cycle: assert property (@(posedge clock) disable iff (rst)
        !write_strobe_n && cmd_latch_en |-> !target_select_n && !addr_latch_en && read_strobe_n)
        else $error("bad command cycle");
    chk_addr_cycle: assert property (@(posedge clock) disable iff (rst)
        !write_strobe_n && addr_latch_en |-> !target_select_n && !cmd_latch_en && read_strobe_n)
        else $error("bad address cycle");
    chk_strobe_excl: assert property (@(posedge clock) disable iff (rst)
        !(!write_strobe_n && !read_strobe_n)) else $error("both strobes low");
    // Upper byte quiet for command or address
    chk_upper_quiet: assert property (@(posedge clock) disable iff (rst)
        (cmd_latch_en || addr_latch_en) |-> io_out[15:8] == 8'h00)
        else $error("upper byte driven");
    chk_reset_first: assert property (@(posedge clock) disable iff (rst)
        !reset_done_r && cmd_latch_en && !write_strobe_n |-> io_out[7:0] == CMD_RESET)
        else $error("first command not reset");
    chk_idle_desel: assert property (@(posedge clock) disable iff (rst)
        target_select_n |-> write_strobe_n && read_strobe_n && io_oe == 16'h0000)
        else $error("strobe while deselected");
    chk_pulse_width: assert property (@(posedge clock) disable iff (rst)
        $fell(write_strobe_n) |-> !write_strobe_n [*3] ##1 write_strobe_n)
        else $error("write pulse width");
    chk_guard_hold: assert property (@(posedge clock) disable iff (rst)
        !reset_done_r |-> !prog_guard_n) else $error("guard released early");
endmodule

// ---- nand_dev_model.sv ----
`timescale 1ns/1ps
module nand_dev_model #(
    parameter int         BUSY_NS = 2000,
    parameter logic [7:0] RD_BASE = 8'hc3,
    parameter logic [7:0] STATUS_CMD = 8'h80 // Arbitrary status command code
) (
    input  wire logic        target_select_n, // Chip enable
    input  wire logic        cmd_latch_en,    // Command latch
    input  wire logic        addr_latch_en,   // Address latch
    input  wire logic        write_strobe_n,  // Write strobe
    input  wire logic        read_strobe_n,   // Read strobe
    input  wire logic        prog_guard_n,    // Write protect
    input  wire logic [15:0] io_out,          // Host value
    input  wire logic [15:0] io_oe,           // Host enable
    output logic      [15:0] io_bus,          // Wire level
    output logic             ready_busy_n,    // Ready pin
    output logic      [7:0]  first_cmd,       // First command
    output logic      [31:0] addr_seen,       // Address bytes
    output logic      [7:0]  wdata_seen,      // Last data in
    output int               n_cmd,           // Commands
    output int               n_wr,            // Data in cycles
    output int               n_bad            // Bad cycles
);
    logic [15:0] held = 16'h0000;
    logic [7:0]  dev_q = 8'h00;
    logic        dev_oe = 1'b0;
    logic        stat_mode = 1'b0;
    int          addr_n = 0;
    int          n_rd = 0;

    // Power-on state
    initial begin
        ready_busy_n = 1'b1;
        n_cmd = 0;
        n_wr = 0;
        n_bad = 0;
        wdata_seen = 8'h00;
    end

    // Wire level, released lines show inverse of last value
    always_comb begin
        if (|io_oe) io_bus = io_out;
        else if (dev_oe) io_bus = {~held[15:8], dev_q};
        else io_bus = ~held;
    end
    always @(io_out, io_oe, dev_q, dev_oe) begin
        if (|io_oe) held = io_out;
        else if (dev_oe) held[7:0] = dev_q;
    end

    ////////////////////////////////////////////////////////////////
    // Latch on write strobe rise
    always @(posedge write_strobe_n) begin
        if (target_select_n === 1'b0) begin
            if (cmd_latch_en && !addr_latch_en && read_strobe_n) begin
                if (n_cmd == 0) first_cmd = io_bus[7:0];
                n_cmd++;
                addr_n = 0;
                // status command selects the status byte
                stat_mode = (io_bus[7:0] == STATUS_CMD);
                if (io_bus[7:0] == 8'hff) begin
                    ready_busy_n = 1'b0;
                    ready_busy_n <= #(BUSY_NS) 1'b1;
                end
            end else if (addr_latch_en && !cmd_latch_en && read_strobe_n && addr_n < 4) begin
                addr_seen[8*addr_n +: 8] = io_bus[7:0];
                addr_n++;
                // column must lie inside one page
                if (addr_n == 2 && addr_seen[15:0] > 16'h083f) n_bad++;
            end else if (!cmd_latch_en && !addr_latch_en && read_strobe_n) begin
                if (prog_guard_n && ready_busy_n) begin
                    wdata_seen = io_bus[7:0];
                    n_wr++;
                end
            end else n_bad++;
        end
    end

    // next data byte, or the status byte in status mode, on each read fall
    always @(negedge read_strobe_n) begin
        if (target_select_n === 1'b0 && !cmd_latch_en && !addr_latch_en
            && write_strobe_n && ready_busy_n) begin
            dev_q = stat_mode ? {6'h00, prog_guard_n, ready_busy_n} : RD_BASE ^ n_rd[7:0];
            dev_oe = 1'b1;
            if (!stat_mode) n_rd++;
        end
    end

    always @(posedge target_select_n) dev_oe = 1'b0;
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench
    import nand_host_pkg::*;
;
    localparam logic [7:0] RD_BASE = 8'hc3;
    localparam logic [7:0] STATUS_CMD = 8'h80;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic op_valid = 1'b0;
    logic [1:0] op_kind = 2'h0;
    logic [7:0] op_cmd = 8'h00;
    logic [11:0] op_column = 12'h000;
    logic [5:0] op_page = 6'h00;
    logic [9:0] op_block = 10'h000;
    logic [15:0] op_wdata = 16'h0000;
    logic rd_ready = 1'b0;
    logic guard_release = 1'b0;
    logic op_ready, rd_valid, reset_done, die_ready, target_select_n, cmd_latch_en;
    logic addr_latch_en, write_strobe_n, read_strobe_n, prog_guard_n, ready_busy_n;
    logic [15:0] rd_data, io_out, io_oe, io_bus;
    logic [7:0] first_cmd, wdata_seen;
    logic [31:0] addr_seen;
    int n_cmd, n_wr, n_bad;
    int n_mismatch = 0;
    int num_checks = 0;

    nand_host #(.BUS16(0)) nand_host_inst (
        .clock(clock), .rst(rst), .op_valid(op_valid), .op_ready(op_ready),
        .op_kind(op_kind), .op_cmd(op_cmd), .op_column(op_column), .op_page(op_page),
        .op_block(op_block), .op_wdata(op_wdata), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data), .guard_release(guard_release),
        .reset_done(reset_done), .die_ready(die_ready),
        .target_select_n(target_select_n), .cmd_latch_en(cmd_latch_en),
        .addr_latch_en(addr_latch_en), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .prog_guard_n(prog_guard_n), .io_out(io_out),
        .io_oe(io_oe), .io_in(io_bus), .ready_busy_n(ready_busy_n));

    nand_dev_model #(.BUSY_NS(2000), .RD_BASE(RD_BASE), .STATUS_CMD(STATUS_CMD))
    nand_dev_model_inst (
        .target_select_n(target_select_n), .cmd_latch_en(cmd_latch_en),
        .addr_latch_en(addr_latch_en), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .prog_guard_n(prog_guard_n), .io_out(io_out),
        .io_oe(io_oe), .io_bus(io_bus), .ready_busy_n(ready_busy_n),
        .first_cmd(first_cmd), .addr_seen(addr_seen), .wdata_seen(wdata_seen),
        .n_cmd(n_cmd), .n_wr(n_wr), .n_bad(n_bad));

    ////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial forever #5 clock = ~clock;
    initial begin
        #400000;
        n_mismatch++;
        wrap_up();
    end

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Present one request, hold until accepted
    task automatic do_op(input logic [1:0] k, input logic [7:0] c, input logic [11:0] col,
                         input logic [5:0] pg, input logic [9:0] blk, input logic [15:0] wd);
        int t;
        t = 0;
        @(posedge clock);
        op_valid <= 1'b1;
        {op_kind, op_cmd, op_column, op_page, op_block, op_wdata} <= {k, c, col, pg, blk, wd};
        do begin
            @(negedge clock);
            t++;
        end while (op_ready !== 1'b1 && t < 500);
        if (t >= 500) n_mismatch++;
        @(posedge clock);
        op_valid <= 1'b0;
    endtask

    // Expected address bytes, first cycle lowest
    function automatic logic [31:0] exp_addr(input logic [11:0] c, input logic [5:0] p,
                                             input logic [9:0] b);
        logic [11:0] k;
        k = c;
        if (c[11]) k[10:6] = 5'h00;
        return {b[9:2], b[1:0], p, 4'h0, k[11:8], k[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [11:0] ccol[3];
        logic [11:0] col;
        logic [5:0] pg;
        logic [9:0] blk;
        logic [15:0] wd;
        logic [7:0] exp_wd;
        logic g;
        int t;
        int exp_wr;
        exp_wr = 0;
        exp_wd = 8'h00;
        ccol = '{12'hfff, 12'h8c5, 12'h000};
        void'($urandom(32'h7f42));
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        check(32'({target_select_n, cmd_latch_en, addr_latch_en, write_strobe_n,
                   read_strobe_n, prog_guard_n, reset_done, io_oe}), 32'h004c_0000);
        @(posedge clock);
        op_valid <= 1'b1;
        op_kind <= OP_ADDR;
        repeat (3) @(negedge clock);
        check(32'(op_ready), 32'h0000_0000);
        @(posedge clock);
        op_valid <= 1'b0;
        do_op(OP_CMD, CMD_RESET, 12'h000, 6'h00, 10'h000, 16'h0000);
        repeat (10) @(negedge clock);
        check(32'({first_cmd, reset_done, die_ready}), 32'({CMD_RESET, 2'b10}));
        t = 0;
        while (die_ready !== 1'b1 && t < 1000) begin
            @(negedge clock);
            t++;
        end
        check(32'(die_ready), 32'h0000_0001);
        for (int i = 0; i < 12; i++) begin
            col = (i < 3) ? ccol[i] : 12'($urandom());
            pg = (i == 0) ? 6'h3f : (i < 3) ? 6'h00 : 6'($urandom());
            blk = (i == 0) ? 10'h3ff : (i < 3) ? 10'h000 : 10'($urandom());
            wd = 16'($urandom());
            g = (i < 2) ? ~i[0] : 1'($urandom());
            @(posedge clock);
            guard_release <= g;
            do_op(OP_CMD, 8'($urandom()) & 8'h7f, 12'h000, 6'h00, 10'h000, 16'h0000);
            do_op(OP_ADDR, 8'h00, col, pg, blk, 16'h0000);
            do_op(OP_WRITE, 8'h00, 12'h000, 6'h00, 10'h000, wd);
            repeat (12) @(negedge clock);
            if (g) begin
                exp_wr++;
                exp_wd = wd[7:0];
            end
            check(32'(n_cmd), 32'(i + 2));
            check(addr_seen, exp_addr(col, pg, blk));
            check(32'(prog_guard_n), 32'(g));
            check({n_wr[23:0], wdata_seen}, {exp_wr[23:0], exp_wd});
            do_op(OP_READ, 8'h00, 12'h000, 6'h00, 10'h000, 16'h0000);
            t = 0;
            while (rd_valid !== 1'b1 && t < 200) begin
                @(negedge clock);
                t++;
            end
            check(32'(rd_data[7:0]), 32'(RD_BASE ^ 8'(i)));
            @(posedge clock);
            rd_ready <= 1'b1;
            @(posedge clock);
            rd_ready <= 1'b0;
        end
        check(32'(n_bad), 32'h0000_0000);
        // Six data writes through the write buffer, one at a time, each checked
        @(posedge clock);
        guard_release <= 1'b1;
        for (int n = 0; n < 6; n++) begin
            wd = (n == 0) ? 16'hffff : 16'($urandom());
            do_op(OP_WRITE, 8'h00, 12'h000, 6'h00, 10'h000, wd);
            repeat (10) @(negedge clock);
            exp_wr++;
            check({n_wr[23:0], wdata_seen}, {exp_wr[23:0], wd[7:0]});
        end
        // Status byte after the status command
        do_op(OP_CMD, STATUS_CMD, 12'h000, 6'h00, 10'h000, 16'h0000);
        do_op(OP_READ, 8'h00, 12'h000, 6'h00, 10'h000, 16'h0000);
        t = 0;
        while (rd_valid !== 1'b1 && t < 200) begin
            @(negedge clock);
            t++;
        end
        check(32'(rd_data[7:0]), 32'h0000_0003);
        @(posedge clock);
        rd_ready <= 1'b1;
        @(posedge clock);
        rd_ready <= 1'b0;
        @(negedge clock);
        check(32'({rd_valid, target_select_n}), 32'h0000_0001);
        wrap_up();
    end
endmodule
